// ===== verilog/osc_enable_reg.sv
// oscillator source control and status for the clock system
// assumes oscillator ticks arrive asynchronously from analogue cells
//
// What this block does
// - after reset the system clock comes from the mid rc source
// - any mix of internal oscillators may run at once
// - ultra low-power oscillator is never a system clock choice
// - ultra low-power oscillator is switched on by hardware on demand
// - slow rc trim loads from calibration row at reset, stays writable
// - slow rc feeds the rtc via 1.024 khz divider, or system clock
// - slow rc is never a pll reference
// - mid rc and fast ring load factory trim at reset
// - mid rc and fast ring may be system clock or pll reference
// - each oscillator except ultra low-power has enable bit and stable flag
// - enabling a second external source is ignored
// - watch crystal may be system clock, its 1 khz only to rtc
// - crystal type field picks source type and start-up time
// - watch low power bit acts only on the watch crystal option
// - crystal configuration writes ignored while crystal is on
// - external clock is stable after six input cycles
// - switching to an unstable source is refused
`include "osc_defs.svh"
`timescale 1ns/1ns
module osc_enable_reg #(
   parameter logic [7:0] SLOW_TRIM_W = 8'h80
) (
   // clock and reset
   input  wire logic              clock,
   input  wire logic              reset_n,
   // register port
   input  wire osc_pkg::osc_bus_s bus,
   output logic [7:0]             rdata,
   // factory calibration row
   input  wire logic [7:0]        cal_slow_rc,
   input  wire logic [7:0]        cal_mid_rc,
   input  wire logic [7:0]        cal_fast_ring,
   // oscillator ticks from the analogue side and the ultra low-power demand
   input  wire logic              slow_rc_tick,
   input  wire logic              mid_rc_tick,
   input  wire logic              fast_ring_tick,
   input  wire logic              crystal_tick,
   input  wire logic              watch_tick,
   input  wire logic              ulp_needed,
   // analogue controls
   output logic                   ultra_low_power_osc_on,
   output logic                   slow_rc_on,
   output logic                   mid_rc_on,
   output logic                   fast_ring_on,
   output logic                   crystal_osc_on,
   output logic                   crystal_amp_on,
   output logic                   watch_osc_on,
   output logic                   watch_crystal_low_power,
   output logic [2:0]             crystal_type_select,
   output logic [7:0]             slow_rc_trim_value,
   output logic [7:0]             mid_rc_trim,
   output logic [7:0]             fast_ring_trim,
   // clock selection
   output osc_pkg::osc_src_e      sys_clock_sel,
   output logic [1:0]             pll_ref_sel,
   output logic                   rtc_slow_rc_div,
   output logic                   rtc_watch_div
);
   // synchronisers for the tick inputs and the consumer request
   logic [5:0] sync1;
   logic [5:0] sync2;
   logic [5:0] sync3;
   wire  [5:0] raw = {ulp_needed, watch_tick, crystal_tick,
                      fast_ring_tick, mid_rc_tick, slow_rc_tick};
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end else begin
         sync1 <= raw;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end
   wire [4:0] tick = sync2[4:0] & ~sync3[4:0];
   wire       ulp_req = sync2[5];

   // control state
   logic [4:0] enable;
   logic [2:0] xsel;
   logic       lowpow;
   logic [7:0] slow_trim;
   logic       cal_pending;
   logic [1:0] pll_sel;
   logic [1:0] rtc_sel;
   osc_pkg::osc_src_e sys_sel;
   wire  [4:0] stable;

   // register decode
   wire wr_en   = bus.wr && bus.addr == `OSC_ENABLE_REG_ADDR;
   wire wr_cfg  = bus.wr && bus.addr == `OSC_CRYSTAL_CFG_ADDR;
   wire wr_trim = bus.wr && bus.addr == `OSC_SLOW_TRIM_ADDR;
   wire wr_sys  = bus.wr && bus.addr == `OSC_SYS_SEL_ADDR;
   wire wr_rtc  = bus.wr && bus.addr == `OSC_RTC_SEL_ADDR;

   // enable write: crystal and watch share pins, second one ignored
   wire req_x   = bus.wdata[`OSC_BIT_CRYSTAL];
   wire req_w   = bus.wdata[`OSC_BIT_WATCH];
   // crystal wins when both are asked for from neither running
   wire keep_x  = req_x && !enable[`OSC_BIT_WATCH];
   wire keep_w  = req_w && !keep_x
                  && !enable[`OSC_BIT_CRYSTAL];
   wire [4:0] next_enable = {keep_w, keep_x, bus.wdata[2:0]};

   // system clock request: only stable, legal sources accepted
   wire [2:0] req_src = bus.wdata[2:0];
   logic      src_ok;
   always_comb begin
      unique case (req_src)
         3'b000:  src_ok = stable[`OSC_BIT_MID_RC];
         3'b001:  src_ok = stable[`OSC_BIT_SLOW_RC];
         3'b010:  src_ok = stable[`OSC_BIT_FAST_RING];
         3'b011:  src_ok = stable[`OSC_BIT_CRYSTAL];
         3'b100:  src_ok = stable[`OSC_BIT_WATCH];
         default: src_ok = 1'b0; // pll is outside; ulp has no code
      endcase
   end
   // pll reference: 0 mid rc, 1 fast ring, 2 crystal; slow rc absent
   wire pll_ok = bus.wdata[5:4] != 2'b11 &&
                 !(bus.wdata[5:4] == 2'b10 &&
                   xsel == `OSC_XSEL_WATCH);

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         enable      <= 5'(`OSC_ENABLE_RESET);
         xsel        <= `OSC_XSEL_WATCH;
         lowpow      <= 1'b0;
         slow_trim   <= 8'h00;
         cal_pending <= 1'b1;
         pll_sel     <= 2'b00;
         rtc_sel     <= 2'b00;
         sys_sel     <= osc_pkg::osc_src_mid_rc;
      end else begin
         cal_pending <= 1'b0;
         if (cal_pending)
            slow_trim <= cal_slow_rc;
         else if (wr_trim)
            slow_trim <= bus.wdata;
         if (wr_en)
            enable <= next_enable;
         if (wr_cfg && !enable[`OSC_BIT_CRYSTAL]) begin
            xsel   <= bus.wdata[2:0];
            lowpow <= bus.wdata[5];
         end
         if (wr_sys && src_ok)
            sys_sel <= osc_pkg::osc_src_e'(req_src);
         if (wr_sys && bus.wdata[7] && pll_ok)
            pll_sel <= bus.wdata[5:4];
         if (wr_rtc)
            rtc_sel <= bus.wdata[1:0];
      end
   end

   // factory trims for mid rc and fast ring latched after release
   logic [7:0] mid_trim;
   logic [7:0] fast_trim;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         mid_trim  <= 8'h00;
         fast_trim <= 8'h00;
      end else if (cal_pending) begin
         mid_trim  <= cal_mid_rc;
         fast_trim <= cal_fast_ring;
      end
   end

   // start-up requirement per source
   logic [10:0] xneed;
   always_comb begin
      unique case (xsel)
         `OSC_XSEL_WATCH:  xneed = 11'(`OSC_WATCH_START);
         `OSC_XSEL_R0:     xneed = 11'(`OSC_XTAL_START_SHORT);
         `OSC_XSEL_R1:     xneed = 11'(`OSC_XTAL_START_SHORT);
         `OSC_XSEL_R2:     xneed = 11'(`OSC_XTAL_START_LONG);
         `OSC_XSEL_R3:     xneed = 11'(`OSC_XTAL_START_LONG);
         `OSC_XSEL_EXTCLK: xneed = 11'(`OSC_EXTCLK_START);
         default:          xneed = 11'(`OSC_XTAL_START_LONG);
      endcase
   end
   wire [10:0] need [5];
   assign need[0] = 11'(`OSC_INT_START);
   assign need[1] = 11'(`OSC_INT_START);
   assign need[2] = 11'(`OSC_INT_START);
   assign need[3] = xneed;
   assign need[4] = 11'(`OSC_WATCH_START);

   // one start-up counter per oscillator except ultra low-power; disable drops stable
   genvar g;
   generate
      for (g = 0; g < 5; g++) begin : g_start
         osc_startup #(.CW(11)) u_start (
            .clock   (clock),
            .reset_n (reset_n),
            .on      (enable[g]),
            .tick    (tick[g]),
            .need    (need[g]),
            .stable  (stable[g])
         );
      end
   endgenerate

   // read mux
   logic [7:0] rmux;
   always_comb begin
      unique case (bus.addr)
         `OSC_ENABLE_REG_ADDR:  rmux = {3'h0, enable};
         `OSC_STABLE_REG_ADDR:  rmux = {3'h0, stable};
         `OSC_CRYSTAL_CFG_ADDR: rmux = {2'h0, lowpow, 2'h0, xsel};
         `OSC_SLOW_TRIM_ADDR:   rmux = slow_trim;
         `OSC_SYS_SEL_ADDR:     rmux = {2'h0, pll_sel, 1'b0, sys_sel};
         `OSC_RTC_SEL_ADDR:     rmux = {6'h00, rtc_sel};
         `OSC_CAL_VIEW_ADDR:    rmux = mid_trim;
         default:               rmux = 8'h00;
      endcase
   end

   wire watch_sel = xsel == `OSC_XSEL_WATCH;
   wire x_en      = enable[`OSC_BIT_CRYSTAL];
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rdata                   <= 8'h00;
         ultra_low_power_osc_on  <= 1'b0;
         slow_rc_on              <= 1'b0;
         mid_rc_on               <= 1'b1;
         fast_ring_on            <= 1'b0;
         crystal_osc_on          <= 1'b0;
         crystal_amp_on          <= 1'b0;
         watch_osc_on            <= 1'b0;
         watch_crystal_low_power <= 1'b0;
         crystal_type_select     <= `OSC_XSEL_WATCH;
         slow_rc_trim_value      <= 8'h00;
         mid_rc_trim             <= 8'h00;
         fast_ring_trim          <= 8'h00;
         sys_clock_sel           <= osc_pkg::osc_src_mid_rc;
         pll_ref_sel             <= 2'b00;
         rtc_slow_rc_div         <= 1'b0;
         rtc_watch_div           <= 1'b0;
      end else begin
         rdata                   <= bus.rd ? rmux : 8'h00;
         ultra_low_power_osc_on  <= ulp_req;
         slow_rc_on              <= enable[`OSC_BIT_SLOW_RC];
         mid_rc_on               <= enable[`OSC_BIT_MID_RC];
         fast_ring_on            <= enable[`OSC_BIT_FAST_RING];
         crystal_osc_on          <= x_en;
         crystal_amp_on          <= x_en && xsel != `OSC_XSEL_EXTCLK;
         watch_osc_on            <= enable[`OSC_BIT_WATCH];
         watch_crystal_low_power <= lowpow && watch_sel;
         crystal_type_select     <= xsel;
         slow_rc_trim_value      <= slow_trim;
         mid_rc_trim             <= mid_trim;
         fast_ring_trim          <= fast_trim;
         sys_clock_sel           <= sys_sel;
         pll_ref_sel             <= pll_sel;
         rtc_slow_rc_div         <= rtc_sel == 2'b01;
         rtc_watch_div           <= rtc_sel == 2'b10;
      end
   end
endmodule

// ===== verilog/osc_defs.svh
// register offsets, field positions, reset values and timing counts
// assumes inclusion by the oscillator control files only
`ifndef OSC_DEFS_SVH
`define OSC_DEFS_SVH
`define OSC_ENABLE_REG_ADDR   4'h0
`define OSC_STABLE_REG_ADDR   4'h1
`define OSC_CRYSTAL_CFG_ADDR  4'h2
`define OSC_SLOW_TRIM_ADDR    4'h3
`define OSC_SYS_SEL_ADDR      4'h4
`define OSC_RTC_SEL_ADDR      4'h5
`define OSC_CAL_VIEW_ADDR     4'h6
`define OSC_BIT_SLOW_RC       0
`define OSC_BIT_MID_RC        1
`define OSC_BIT_FAST_RING     2
`define OSC_BIT_CRYSTAL       3
`define OSC_BIT_WATCH         4
`define OSC_ENABLE_RESET      8'h02
`define OSC_SYS_SEL_RESET     3'h0
`define OSC_XSEL_WATCH        3'h0
`define OSC_XSEL_R0           3'h1
`define OSC_XSEL_R1           3'h2
`define OSC_XSEL_R2           3'h3
`define OSC_XSEL_R3           3'h4
`define OSC_XSEL_EXTCLK       3'h5
`define OSC_EXTCLK_START      6
`define OSC_XTAL_START_SHORT  256
`define OSC_XTAL_START_LONG   1024
`define OSC_WATCH_START       1024
`define OSC_INT_START         64
`endif

// ===== verilog/osc_pkg.sv
// types shared by the oscillator control files
// assumes osc_defs.svh carries the numbers
package osc_pkg;
   typedef enum logic [2:0] {
      osc_src_mid_rc    = 3'b000,
      osc_src_slow_rc   = 3'b001,
      osc_src_fast_ring = 3'b010,
      osc_src_crystal   = 3'b011,
      osc_src_watch     = 3'b100,
      osc_src_pll       = 3'b101
   } osc_src_e;
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } osc_bus_s;
endpackage

// ===== verilog/osc_startup.sv
// start-up counter: counts edges of one oscillator until it is stable
// assumes tick is a one-cycle pulse already synchronised to clock
`timescale 1ns/1ns
module osc_startup #(
   parameter int CW = 11
) (
   // clock and reset
   input  wire logic          clock,
   input  wire logic          reset_n,
   // control
   input  wire logic          on,
   input  wire logic          tick,
   input  wire logic [CW-1:0] need,
   // state
   output logic               stable
);
   logic [CW-1:0] count;
   wire           done = (count >= need);
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         count  <= '0;
         stable <= 1'b0;
      end else if (!on) begin
         count  <= '0;
         stable <= 1'b0;
      end else begin
         if (tick && !done)
            count <= count + 1'b1;
         stable <= done;
      end
   end
endmodule

// ===== bench/osc_enable_reg_props.sv
// checker on the oscillator control ports
// assumes binding into osc_enable_reg, one clock domain
`timescale 1ns/1ns
module osc_enable_reg_props (
   // clock and reset
   input wire logic              clock,
   input wire logic              reset_n,
   // calibration row and demand
   input wire logic [7:0]        cal_slow_rc,
   input wire logic [7:0]        cal_mid_rc,
   input wire logic [7:0]        cal_fast_ring,
   input wire logic              ulp_needed,
   // oscillator controls
   input wire logic              ultra_low_power_osc_on,
   input wire logic              slow_rc_on,
   input wire logic              mid_rc_on,
   input wire logic              fast_ring_on,
   input wire logic              crystal_osc_on,
   input wire logic              crystal_amp_on,
   input wire logic              watch_osc_on,
   input wire logic              watch_crystal_low_power,
   input wire logic [2:0]        crystal_type_select,
   input wire logic [7:0]        slow_rc_trim_value,
   input wire logic [7:0]        mid_rc_trim,
   input wire logic [7:0]        fast_ring_trim,
   // selection
   input wire osc_pkg::osc_src_e sys_clock_sel,
   input wire logic [1:0]        pll_ref_sel
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (!reset_n);
   // enables in system select code order
   wire logic [4:0] src_on = {watch_osc_on, crystal_osc_on, fast_ring_on,
                              slow_rc_on, mid_rc_on};
   property p_reset_src;
      $rose(reset_n) |->
         sys_clock_sel == osc_pkg::osc_src_mid_rc && mid_rc_on;
   endproperty
   a_reset_src: assert property (p_reset_src)
      else $error("source after reset wrong");
   property p_trim_load;
      $rose(reset_n) |-> ##3 {slow_rc_trim_value, mid_rc_trim, fast_ring_trim}
         == {cal_slow_rc, cal_mid_rc, cal_fast_ring};
   endproperty
   a_trim_load: assert property (p_trim_load)
      else $error("trim not loaded");
   property p_ulp;
      $rose(ulp_needed) |-> ##3 ultra_low_power_osc_on;
   endproperty
   a_ulp: assert property (p_ulp)
      else $error("ultra low power osc not started");
   property p_no_ulp_sel;
      sys_clock_sel <= osc_pkg::osc_src_watch;
   endproperty
   a_no_ulp_sel: assert property (p_no_ulp_sel)
      else $error("illegal system select");
   property p_sel_on;
      $changed(sys_clock_sel) |-> src_on[sys_clock_sel];
   endproperty
   a_sel_on: assert property (p_sel_on)
      else $error("switched to idle source");
   property p_one_ext;
      !(crystal_osc_on && watch_osc_on);
   endproperty
   a_one_ext: assert property (p_one_ext)
      else $error("two external sources on");
   property p_lp;
      watch_crystal_low_power |-> crystal_type_select == 3'h0;
   endproperty
   a_lp: assert property (p_lp)
      else $error("low power outside watch type");
   property p_cfg_lock;
      crystal_osc_on && $past(crystal_osc_on) |-> $stable(crystal_type_select);
   endproperty
   a_cfg_lock: assert property (p_cfg_lock)
      else $error("crystal type changed while on");
   property p_pll;
      pll_ref_sel != 2'h3;
   endproperty
   a_pll: assert property (p_pll)
      else $error("illegal pll reference");
   property p_amp;
      crystal_amp_on == (crystal_osc_on && crystal_type_select != 3'h5);
   endproperty
   a_amp: assert property (p_amp)
      else $error("amplifier state wrong");
   c_xtal: cover property (sys_clock_sel == osc_pkg::osc_src_crystal);
   c_lp: cover property (watch_crystal_low_power);
   c_ulp: cover property ($rose(ultra_low_power_osc_on));
endmodule

// ===== bench/osc_partner.sv
// oscillator cells: each runs only while its enable is high
// assumes enables in register bit order, slow rc first
`timescale 1ns/1ns
module osc_partner #(
   parameter int HALF_NS = 52
) (
   // enables
   input  wire logic [4:0] osc_on,
   // oscillator outputs, low while stopped
   output logic      [4:0] tick
);
   initial tick = 5'h00;
   for (genvar i = 0; i < 5; i++) begin : g_osc
      // fixed period per cell, no drift between cycles
      always #(HALF_NS + i) tick[i] = osc_on[i] ? ~tick[i] : 1'b0;
   end
endmodule

// ===== bench/tb_top.sv
// register level bench for the oscillator control block
// assumes osc_enable_reg, osc_partner and osc_enable_reg_props compiled before
`timescale 1ns/1ns
module tb_top;
   logic              clock = 1'b0;
   logic              reset_n = 1'b0;
   logic              ulp_needed = 1'b0;
   osc_pkg::osc_bus_s bus = '0;
   logic [7:0]        cal_slow_rc = 8'h3c;
   logic [7:0]        cal_mid_rc = 8'ha5;
   logic [7:0]        cal_fast_ring = 8'h69;
   logic [7:0]        rdata, d, slow_rc_trim_value;
   logic [7:0]        mid_rc_trim, fast_ring_trim;
   logic [4:0]        tick;
   logic              ultra_low_power_osc_on, slow_rc_on, mid_rc_on;
   logic              fast_ring_on, crystal_osc_on, crystal_amp_on;
   logic              watch_osc_on, watch_crystal_low_power;
   logic              rtc_slow_rc_div, rtc_watch_div;
   logic [2:0]        crystal_type_select;
   logic [1:0]        pll_ref_sel;
   osc_pkg::osc_src_e sys_clock_sel;
   int                mismatches = 0;
   int                cmp_count = 0;
   int                edges = 0;
   always #4 clock = ~clock;
   always @(posedge tick[3]) edges++;
   osc_enable_reg u_dut (.clock, .reset_n, .bus, .rdata, .cal_slow_rc, .cal_mid_rc,
      .cal_fast_ring, .slow_rc_tick(tick[0]), .mid_rc_tick(tick[1]),
      .fast_ring_tick(tick[2]), .crystal_tick(tick[3]), .watch_tick(tick[4]),
      .ulp_needed, .ultra_low_power_osc_on, .slow_rc_on, .mid_rc_on,
      .fast_ring_on, .crystal_osc_on, .crystal_amp_on, .watch_osc_on,
      .watch_crystal_low_power, .crystal_type_select, .slow_rc_trim_value,
      .mid_rc_trim, .fast_ring_trim, .sys_clock_sel, .pll_ref_sel,
      .rtc_slow_rc_div, .rtc_watch_div);
   osc_partner u_osc (.osc_on({watch_osc_on, crystal_osc_on, fast_ring_on,
      mid_rc_on, slow_rc_on}), .tick);
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e,
                      input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge clock);
      bus <= '{a, v, 1'b1, 1'b0};
      @(posedge clock);
      bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge clock);
      bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge clock);
      bus.rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic rc(input logic [3:0] a, input logic [7:0] e,
                     input string n);
      rd(a);
      chk(n, e, d);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // wait until all stable bits in the mask are set
   task automatic poll(input logic [7:0] m);
      int i;
      for (i = 0; i < 900; i++) begin
         rd(4'h1);
         if ((d & m) === m)
            break;
      end
      if (i == 900) begin
         mismatches++;
         $display("Error stable wait expected %h seen %h", m, d);
         print_verdict();
      end
   endtask
   initial begin
      repeat (3) @(posedge clock);
      reset_n <= 1'b1;
      idle(2);
      rc(4'h0, 8'h02, "enable reset");
      rc(4'h4, 8'h00, "select reset");
      rc(4'h3, 8'h3c, "slow trim load");
      rc(4'h6, 8'ha5, "mid trim load");
      chk("fast trim", 8'h69, fast_ring_trim);
      chk("mid trim out", 8'ha5, mid_rc_trim);
      rc(4'hf, 8'h00, "unmapped");
      wr(4'h3, 8'h5a);
      rc(4'h3, 8'h5a, "slow trim write");
      chk("slow trim out", 8'h5a, slow_rc_trim_value);
      wr(4'h4, 8'h01);
      rc(4'h4, 8'h00, "idle source select");
      wr(4'h0, 8'h07);
      poll(8'h07);
      chk("internal on", 8'h07,
          8'({fast_ring_on, mid_rc_on, slow_rc_on}));
      wr(4'h4, 8'h01);
      rc(4'h4, 8'h01, "slow rc select");
      wr(4'h4, 8'h92);
      rc(4'h4, 8'h12, "pll fast ring");
      chk("pll ref", 8'h01, 8'(pll_ref_sel));
      wr(4'h4, 8'hb2);
      rc(4'h4, 8'h12, "pll slow rc");
      chk("pll ref kept", 8'h01, 8'(pll_ref_sel));
      wr(4'h4, 8'h05);
      rc(4'h4, 8'h12, "select code 5");
      wr(4'h2, 8'h25);
      edges = 0;
      wr(4'h0, 8'h1f);
      rc(4'h0, 8'h0f, "both external");
      chk("crystal on", 8'h01, 8'(crystal_osc_on));
      wr(4'h2, 8'h20);
      rc(4'h2, 8'h25, "locked config");
      poll(8'h08);
      chk("start edges", 8'h06, 8'(edges));
      chk("amp in ext clock", 8'h00, 8'(crystal_amp_on));
      chk("low power off", 8'h00, 8'(watch_crystal_low_power));
      wr(4'h4, 8'h03);
      idle(2);
      chk("crystal select", 8'h03, 8'(sys_clock_sel));
      wr(4'h4, 8'h00);
      wr(4'h0, 8'h03);
      idle(2);
      rc(4'h1, 8'h03, "stable after off");
      wr(4'h0, 8'h13);
      wr(4'h0, 8'h1b);
      rc(4'h0, 8'h13, "second external");
      chk("watch on", 8'h01, 8'(watch_osc_on));
      wr(4'h5, 8'h02);
      idle(2);
      chk("rtc watch", 8'h01, 8'(rtc_watch_div));
      wr(4'h5, 8'h01);
      idle(2);
      chk("rtc slow rc", 8'h01, 8'(rtc_slow_rc_div));
      wr(4'h0, 8'h03);
      for (int t = 0; t < 6; t++) begin
         wr(4'h2, 8'h20 | 8'(t));
         idle(2);
         chk("type", 8'(t), 8'(crystal_type_select));
         chk("low power", 8'(t == 0), 8'(watch_crystal_low_power));
      end
      @(posedge clock);
      ulp_needed <= 1'b1;
      idle(4);
      chk("ulp on", 8'h01, 8'(ultra_low_power_osc_on));
      print_verdict();
   end
endmodule
bind osc_enable_reg osc_enable_reg_props u_props (.clock, .reset_n, .cal_slow_rc,
   .cal_mid_rc, .cal_fast_ring, .ulp_needed, .ultra_low_power_osc_on,
   .slow_rc_on, .mid_rc_on, .fast_ring_on, .crystal_osc_on, .crystal_amp_on,
   .watch_osc_on, .watch_crystal_low_power, .crystal_type_select,
   .slow_rc_trim_value, .mid_rc_trim, .fast_ring_trim, .sys_clock_sel,
   .pll_ref_sel);
